// ---- core/pie_top.sv ----
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pie_regs.svh"

module pie_top #(
    parameter int PIN_COUNT = 100
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  FLAG1,
    input  wire logic [7:0]  FLAG2,
    input  wire logic [7:0]  FLAG3,
    output logic [7:0]       REQ1,
    output logic [7:0]       REQ2,
    output logic [7:0]       REQ3,
    output logic             HIGH_REQ,
    output logic             LOW_REQ,
    output logic             IRQ
);

    pie_pkg::pie_core_regs_t s;
    pie_pkg::pie_core_regs_t next_s;

    logic [7:0]  wdata;
    logic        wr_stb;
    logic        bad_stb;
    logic        addr_hit;
    logic [7:0]  rd_data;
    logic [7:0]  en3_mask;
    logic [7:0]  prio3_mask;
    logic [7:0]  gate1;
    logic [7:0]  gate2;
    logic [7:0]  gate3;
    logic [7:0]  pend1;
    logic [7:0]  pend2;
    logic [7:0]  pend3;
    logic        any_high;
    logic        any_low;
    logic        prio_on;
    logic        rsvd_write;
    logic [3:0]  evt;
    logic [3:0]  evt_status;
    logic [3:0]  evt_enable;
    logic        evt_clr_stb;
    logic        evt_en_stb;

    // merge a write into a register, touching only the stored bits
    function automatic logic [7:0] pie_merge(
        input logic [7:0] old,
        input logic [7:0] data,
        input logic [7:0] mask
    );
        pie_merge = (old & ~mask) | (data & mask);
    endfunction

    // does the current address name this register
    function automatic logic pie_sel(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        pie_sel = (addr == offset);
    endfunction

    assign wdata = PWDATA[7:0];

    // package variants decide which enable bits physically exist
    always_comb begin
        en3_mask   = `PIE_MASK_EN3_BASE;
        prio3_mask = `PIE_MASK_EN3_BASE;
        if (PIN_COUNT >= `PIE_PINS_LARGE) begin
            en3_mask   = en3_mask | `PIE_MASK_EN3_SSP2;
            prio3_mask = prio3_mask | `PIE_MASK_EN3_SSP2;
        end
        if (PIN_COUNT >= `PIE_PINS_MID) begin
            prio3_mask = prio3_mask | `PIE_MASK_EN3_UART2;
        end
    end

    // second uart enables never take a software write
    logic [7:0] en3_wr_mask;
    assign en3_wr_mask = en3_mask & ~`PIE_MASK_EN3_UART2;

    // address decode
    always_comb begin
        addr_hit = 1'b0;
        rd_data  = `PIE_ZERO8;
        case (PADDR)
            `PIE_OFF_EN1: begin
                addr_hit = 1'b1;
                rd_data  = s.en1 & `PIE_MASK_EN1;
            end
            `PIE_OFF_EN2: begin
                addr_hit = 1'b1;
                rd_data  = s.en2 & `PIE_MASK_EN2;
            end
            `PIE_OFF_EN3: begin
                addr_hit = 1'b1;
                rd_data  = s.en3 & en3_mask;
            end
            `PIE_OFF_PRIO1: begin
                addr_hit = 1'b1;
                rd_data  = s.prio1 & `PIE_MASK_PRIO1;
            end
            `PIE_OFF_PRIO2: begin
                addr_hit = 1'b1;
                rd_data  = s.prio2 & `PIE_MASK_PRIO2;
            end
            `PIE_OFF_PRIO3: begin
                addr_hit = 1'b1;
                rd_data  = s.prio3 & prio3_mask;
            end
            `PIE_OFF_CTRL: begin
                addr_hit = 1'b1;
                rd_data  = s.ctrl & `PIE_MASK_CTRL;
            end
            `PIE_OFF_EVT_STATUS: begin
                addr_hit = 1'b1;
                rd_data  = {4'h0, evt_status};
            end
            `PIE_OFF_EVT_CLEAR: begin
                // write-only, reads back zero
                addr_hit = 1'b1;
                rd_data  = `PIE_ZERO8;
            end
            `PIE_OFF_EVT_ENABLE: begin
                addr_hit = 1'b1;
                rd_data  = {4'h0, evt_enable};
            end
            `PIE_OFF_REQ_VIEW: begin
                addr_hit = 1'b1;
                rd_data  = {6'h00, s.low_req, s.high_req};
            end
            default: begin
                addr_hit = 1'b0;
                rd_data  = `PIE_ZERO8;
            end
        endcase
    end

    // request gating; flags are only read, never cleared here
    assign gate1 = `PIE_MASK_EN1;
    assign gate2 = `PIE_GATE_EN2;
    assign gate3 = en3_mask;
    assign pend1 = FLAG1 & s.en1 & gate1;
    assign pend2 = FLAG2 & s.en2 & gate2;
    assign pend3 = FLAG3 & s.en3 & gate3;

    assign prio_on = s.ctrl[`PIE_CTRL_PRIO_EN];

    // without priority levels every request rides the high line
    always_comb begin
        if (prio_on) begin
            any_high = |(pend1 & s.prio1) | |(pend2 & s.prio2)
                     | |(pend3 & s.prio3);
            any_low  = |(pend1 & ~s.prio1) | |(pend2 & ~s.prio2)
                     | |(pend3 & ~s.prio3);
        end else begin
            any_high = |pend1 | |pend2 | |pend3;
            any_low  = 1'b0;
        end
    end

    // a set reserved bit is kept, but flagged as a software slip
    assign rsvd_write = wr_stb && pie_sel(PADDR, `PIE_OFF_EN2)
                     && wdata[`PIE_EN2_RESERVED];

    always_comb begin
        evt = `PIE_EVT_ZERO;
        evt[`PIE_EVT_HIGH_RISE]  = any_high && !s.high_req;
        evt[`PIE_EVT_LOW_RISE]   = any_low && !s.low_req;
        evt[`PIE_EVT_RSVD_WRITE] = rsvd_write;
        evt[`PIE_EVT_BAD_ADDR]   = bad_stb;
    end

    assign evt_clr_stb = wr_stb && pie_sel(PADDR, `PIE_OFF_EVT_CLEAR);
    assign evt_en_stb  = wr_stb && pie_sel(PADDR, `PIE_OFF_EVT_ENABLE);

    // register writes and request outputs
    always_comb begin
        next_s = s;
        if (wr_stb) begin
            case (PADDR)
                `PIE_OFF_EN1: begin
                    next_s.en1 = pie_merge(s.en1, wdata,
                                           `PIE_MASK_EN1);
                end
                `PIE_OFF_EN2: begin
                    next_s.en2 = pie_merge(s.en2, wdata,
                                           `PIE_MASK_EN2);
                end
                `PIE_OFF_EN3: begin
                    next_s.en3 = pie_merge(s.en3, wdata,
                                           en3_wr_mask);
                end
                `PIE_OFF_PRIO1: begin
                    next_s.prio1 = pie_merge(s.prio1, wdata,
                                             `PIE_MASK_PRIO1);
                end
                `PIE_OFF_PRIO2: begin
                    next_s.prio2 = pie_merge(s.prio2, wdata,
                                             `PIE_MASK_PRIO2);
                end
                `PIE_OFF_PRIO3: begin
                    next_s.prio3 = pie_merge(s.prio3, wdata, prio3_mask);
                end
                `PIE_OFF_CTRL: begin
                    next_s.ctrl = pie_merge(s.ctrl, wdata,
                                            `PIE_MASK_CTRL);
                end
                default: begin
                    next_s.ctrl = s.ctrl;
                end
            endcase
        end
        next_s.req1     = pend1;
        next_s.req2     = pend2;
        next_s.req3     = pend3;
        next_s.high_req = any_high;
        next_s.low_req  = any_low;
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s.en1      <= `PIE_RST_EN;
            s.en2      <= `PIE_RST_EN;
            s.en3      <= `PIE_RST_EN;
            s.prio1    <= `PIE_RST_PRIO;
            s.prio2    <= `PIE_RST_PRIO;
            s.prio3    <= `PIE_RST_PRIO;
            s.ctrl     <= `PIE_RST_CTRL;
            s.req1     <= `PIE_ZERO8;
            s.req2     <= `PIE_ZERO8;
            s.req3     <= `PIE_ZERO8;
            s.high_req <= 1'b0;
            s.low_req  <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    pie_apb_slave u_apb (
        .clk      (CLK),
        .resetn   (RESETN),
        .psel     (PSEL),
        .penable  (PENABLE),
        .pwrite   (PWRITE),
        .pstrb    (PSTRB),
        .rd_data  (rd_data),
        .addr_hit (addr_hit),
        .prdata   (PRDATA),
        .pready   (PREADY),
        .pslverr  (PSLVERR),
        .wr_stb   (wr_stb),
        .bad_stb  (bad_stb)
    );

    pie_evt_status u_evt (
        .clk      (CLK),
        .resetn   (RESETN),
        .evt      (evt),
        .clr_stb  (evt_clr_stb),
        .clr_data (wdata[3:0]),
        .en_stb   (evt_en_stb),
        .en_data  (wdata[3:0]),
        .status   (evt_status),
        .enable   (evt_enable),
        .irq      (IRQ)
    );

    // the gates drop unstored and reserved bits so requests show only real sources
    assign REQ1     = s.req1;
    assign REQ2     = s.req2;
    assign REQ3     = s.req3;
    assign HIGH_REQ = s.high_req;
    assign LOW_REQ  = s.low_req;

endmodule

`default_nettype wire

// ---- core/pie_regs.svh ----
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH

// register byte offsets on the APB side
`define PIE_OFF_EN1        8'h00
`define PIE_OFF_EN2        8'h04
`define PIE_OFF_EN3        8'h08
`define PIE_OFF_PRIO1      8'h0C
`define PIE_OFF_PRIO2      8'h10
`define PIE_OFF_PRIO3      8'h14
`define PIE_OFF_CTRL       8'h18
`define PIE_OFF_EVT_STATUS 8'h1C
`define PIE_OFF_EVT_CLEAR  8'h20
`define PIE_OFF_EVT_ENABLE 8'h24
`define PIE_OFF_REQ_VIEW   8'h28

// enable register 1 fields
`define PIE_EN1_CAPCMP1    2
`define PIE_EN1_TIMER2     1
`define PIE_EN1_TIMER1     0

// enable register 2 fields
`define PIE_EN2_OSC_FAIL   7
`define PIE_EN2_COMPARATOR 6
`define PIE_EN2_ETHERNET   5
`define PIE_EN2_RESERVED   4
`define PIE_EN2_SSP1_COLL  3
`define PIE_EN2_UNIMPL     2
`define PIE_EN2_TIMER3     1
`define PIE_EN2_CAPCMP2    0

// enable register 3 fields
`define PIE_EN3_SSP2       7
`define PIE_EN3_SSP2_COLL  6
`define PIE_EN3_UART2_RX   5
`define PIE_EN3_UART2_TX   4
`define PIE_EN3_TIMER4     3
`define PIE_EN3_CAPCMP5    2
`define PIE_EN3_CAPCMP4    1
`define PIE_EN3_CAPCMP3    0

// control register fields
`define PIE_CTRL_PRIO_EN   0

// event status fields
`define PIE_EVT_HIGH_RISE  0
`define PIE_EVT_LOW_RISE   1
`define PIE_EVT_RSVD_WRITE 2
`define PIE_EVT_BAD_ADDR   3

// storage masks and reset values
`define PIE_MASK_EN1       8'h07
`define PIE_MASK_EN2       8'hFB
`define PIE_GATE_EN2       8'hEB
`define PIE_MASK_EN3_BASE  8'h0F
`define PIE_MASK_EN3_SSP2  8'hC0
`define PIE_MASK_EN3_UART2 8'h30
`define PIE_MASK_PRIO1     8'h07
`define PIE_MASK_PRIO2     8'hFB
`define PIE_MASK_CTRL      8'h01
`define PIE_RST_EN         8'h00
`define PIE_RST_PRIO       8'hFF
`define PIE_RST_CTRL       8'h00
`define PIE_ZERO8          8'h00
`define PIE_PAD24          24'h000000
`define PIE_EVT_ZERO       4'h0
`define PIE_PINS_LARGE     100
`define PIE_PINS_MID       80

`endif

// ---- core/pie_pkg.sv ----
package pie_pkg;

    typedef enum logic [0:0] {
        PIE_APB_IDLE   = 1'b0,
        PIE_APB_ACCESS = 1'b1
    } pie_apb_state_t;

    typedef struct packed {
        pie_apb_state_t phase;
        logic [31:0]    prdata;
        logic           pslverr;
    } pie_apb_regs_t;

    typedef struct packed {
        logic [3:0] status;
        logic [3:0] enable;
        logic       irq;
    } pie_evt_regs_t;

    typedef struct packed {
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [7:0] prio1;
        logic [7:0] prio2;
        logic [7:0] prio3;
        logic [7:0] ctrl;
        logic [7:0] req1;
        logic [7:0] req2;
        logic [7:0] req3;
        logic       high_req;
        logic       low_req;
    } pie_core_regs_t;

endpackage

// ---- core/pie_apb_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pie_regs.svh"

module pie_apb_slave (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  pstrb,
    input  wire logic [7:0]  rd_data,
    input  wire logic        addr_hit,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             wr_stb,
    output logic             bad_stb
);

    pie_pkg::pie_apb_regs_t s;
    pie_pkg::pie_apb_regs_t next_s;

    // read data captured in setup so the access phase answers from a flop
    always_comb begin
        next_s = s;
        if (psel && !penable) begin
            next_s.phase   = pie_pkg::PIE_APB_ACCESS;
            next_s.pslverr = !addr_hit;
            if (!pwrite && addr_hit) begin
                next_s.prdata = {`PIE_PAD24, rd_data};
            end else begin
                next_s.prdata = {`PIE_PAD24, `PIE_ZERO8};
            end
        end else if (psel && penable) begin
            next_s.phase = pie_pkg::PIE_APB_IDLE;
        end else begin
            next_s.phase   = pie_pkg::PIE_APB_IDLE;
            next_s.pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = s.prdata;
    // error only in an access phase this slave itself entered
    assign pslverr = s.pslverr && psel && penable
                  && (s.phase == pie_pkg::PIE_APB_ACCESS);
    // only byte lane 0 carries register bits
    assign wr_stb  = psel && penable && pwrite && pstrb[0] && addr_hit;
    assign bad_stb = psel && penable && !addr_hit;

endmodule

`default_nettype wire

// ---- core/pie_evt_status.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pie_regs.svh"

module pie_evt_status (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] evt,
    input  wire logic       clr_stb,
    input  wire logic [3:0] clr_data,
    input  wire logic       en_stb,
    input  wire logic [3:0] en_data,
    output logic [3:0]      status,
    output logic [3:0]      enable,
    output logic            irq
);

    pie_pkg::pie_evt_regs_t s;
    pie_pkg::pie_evt_regs_t next_s;

    always_comb begin
        next_s = s;
        if (clr_stb) begin
            next_s.status = s.status & ~clr_data;
        end
        // a new event beats a clear in the same cycle
        next_s.status = next_s.status | evt;
        if (en_stb) begin
            next_s.enable = en_data;
        end
        next_s.irq = |(next_s.status & next_s.enable);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign status = s.status;
    assign enable = s.enable;
    assign irq    = s.irq;

endmodule

`default_nettype wire

// ---- dv/pie_chk_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module pie_chk #(
    parameter int PIN_COUNT = 100
) (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [7:0]  FLAG1,
    input wire logic [7:0]  FLAG2,
    input wire logic [7:0]  FLAG3,
    input wire logic [7:0]  REQ1,
    input wire logic [7:0]  REQ2,
    input wire logic [7:0]  REQ3,
    input wire logic        HIGH_REQ,
    input wire logic        LOW_REQ,
    input wire logic        IRQ
);
    // sync serial 2 gates only on the largest variant
    localparam logic [7:0] EN3_GATE = (PIN_COUNT >= 100) ? 8'hCF : 8'h0F;
    logic acc;
    logic rd_acc;
    assign acc = PSEL && PENABLE && PREADY;
    assign rd_acc = acc && !PWRITE;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    chk_req_flag: assert property (
        ({REQ1, REQ2, REQ3} & ~$past({FLAG1, FLAG2, FLAG3})) == 24'h0)
        else $error("request without its flag");
    chk_req_holes: assert property (
        REQ1[7:3] == 5'h0 && (REQ2 & 8'h14) == 8'h0
        && (REQ3 & ~EN3_GATE) == 8'h0)
        else $error("request on a bit that never gates");
    chk_en2_write: assert property (
        (acc && PWRITE && PSTRB[0] && PADDR == 8'h04 && FLAG2 == 8'hFF)
        ##1 FLAG2 == 8'hFF |=> REQ2 == ($past(PWDATA[7:0], 2) & 8'hEB))
        else $error("enable 2 write not seen on requests");
    chk_en3_write: assert property (
        (acc && PWRITE && PSTRB[0] && PADDR == 8'h08 && FLAG3 == 8'hFF)
        ##1 FLAG3 == 8'hFF |=> REQ3 == ($past(PWDATA[7:0], 2) & EN3_GATE))
        else $error("enable 3 write not seen on requests");
    chk_level_any: assert property (
        (HIGH_REQ || LOW_REQ) == (|{REQ1, REQ2, REQ3}))
        else $error("core request level disagrees with requests");
    chk_err_phase: assert property (
        PSLVERR |-> PSEL && PENABLE && PRDATA == 32'h0)
        else $error("slave error outside access phase or with data");
    chk_err_addr: assert property (
        acc && PADDR > 8'h28 |-> PSLVERR)
        else $error("unmapped access without slave error");
    chk_rd_holes: assert property (
        rd_acc && PADDR == 8'h04 |-> PRDATA[2] == 1'h0
        && PRDATA[31:8] == 24'h0)
        else $error("enable 2 unimplemented bit reads one");
    chk_rd_uart: assert property (
        rd_acc && PADDR == 8'h08 |-> PRDATA[5:4] == 2'h0)
        else $error("enable 3 read-only bits read one");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk = 1'h0;
    logic        resetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  flag1 = 8'h00;
    logic [7:0]  flag2 = 8'h00;
    logic [7:0]  flag3 = 8'h00;
    wire  [31:0] prdata;
    wire  [31:0] prdata2;
    wire         pready;
    wire         pslverr;
    wire  [7:0]  req1;
    wire  [7:0]  req2;
    wire  [7:0]  req3;
    wire         high_req;
    wire         low_req;
    wire         irq;
    wire  [31:0] reqs = {8'h00, req3, req2, req1};
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [31:0] ex;
    logic        er;
    logic [7:0]  a;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [7:0]  rst_val [7] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'hFB,
                                 8'hFF, 8'h00};
    logic [7:0]  wb [3] = '{8'h07, 8'hFB, 8'hCF};
    logic [7:0]  gate [3] = '{8'h07, 8'hEB, 8'hCF};

    always #10 clk = ~clk;

    pie_top #(.PIN_COUNT(100)) pie_top_i (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FLAG1(flag1), .FLAG2(flag2), .FLAG3(flag3), .REQ1(req1),
        .REQ2(req2), .REQ3(req3), .HIGH_REQ(high_req),
        .LOW_REQ(low_req), .IRQ(irq)
    );

    // smaller variant shares the bus, the testbench compares only its read data
    pie_top #(.PIN_COUNT(80)) pie_top_small_i (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata2), .PREADY(), .PSLVERR(), .FLAG1(flag1),
        .FLAG2(flag2), .FLAG3(flag3), .REQ1(), .REQ2(), .REQ3(),
        .HIGH_REQ(), .LOW_REQ(), .IRQ()
    );

    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // entered just after a rising edge; idle cycle after each transfer
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data, input logic [3:0] strb);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        rd2 = prdata2;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'h1, addr, data, 4'hF);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        apb(1'h0, addr, 32'h0, 4'hF);
        chk($sformatf("read %h", addr), {24'h0, exp}, rd);
    endtask

    // every scenario finishes well inside this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        for (a = 8'h00; a < 8'h1C; a = a + 8'h04) begin
            rdchk(a, rst_val[a[4:2]]);
        end
        rdchk(8'h14, 8'hFF);
        chk("small priority 3", 32'h3F, rd2);
        for (a = 8'h00; a < 8'h0C; a = a + 8'h04) begin
            wr(a, 32'hFFFFFFFF);
            rdchk(a, wb[a[3:2]]);
        end
        chk("small enable 3", 32'h0F, rd2);
        rdchk(8'h1C, 8'h04);
        apb(1'h1, 8'h08, 32'h0, 4'h0);
        rdchk(8'h08, 8'hCF);
        for (a = 8'h00; a < 8'h0C; a = a + 8'h04) wr(a, 32'h0);
        rdchk(8'h04, 8'h00);
        flag1 <= 8'hFF;
        flag2 <= 8'hFF;
        flag3 <= 8'hFF;
        for (int r = 0; r < 3; r++) begin
            for (int b = 0; b < 8; b++) begin
                wr(8'(4 * r), 32'h1 << b);
                @(posedge clk);
                ex = 32'(gate[r] & (8'h01 << b)) << (8 * r);
                chk("request", ex, reqs);
            end
            wr(8'(4 * r), 32'h0);
        end
        // single source, priority levels off then on
        flag1 <= 8'h01;
        flag2 <= 8'h00;
        flag3 <= 8'h00;
        wr(8'h00, 32'h1);
        @(posedge clk);
        chk("levels", 32'h1, {30'h0, low_req, high_req});
        wr(8'h18, 32'h1);
        @(posedge clk);
        chk("levels", 32'h1, {30'h0, low_req, high_req});
        wr(8'h0C, 32'h0);
        @(posedge clk);
        chk("levels", 32'h2, {30'h0, low_req, high_req});
        rdchk(8'h28, 8'h02);
        flag1 <= 8'h00;
        repeat (2) @(posedge clk);
        chk("request", 32'h0, reqs);
        // event status, enable and clear
        wr(8'h20, 32'hF);
        rdchk(8'h1C, 8'h00);
        apb(1'h0, 8'h40, 32'h0, 4'hF);
        chk("slave error", 32'h1, {31'h0, er});
        chk("unmapped read", 32'h0, rd);
        rdchk(8'h1C, 8'h08);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h24, 32'h8);
        @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h24, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h24, 32'h8);
        wr(8'h20, 32'h8);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdchk(8'h1C, 8'h00);
        results();
    end
endmodule

bind pie_top pie_chk #(.PIN_COUNT(PIN_COUNT)) pie_chk_i (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FLAG1(FLAG1), .FLAG2(FLAG2), .FLAG3(FLAG3), .REQ1(REQ1),
    .REQ2(REQ2), .REQ3(REQ3), .HIGH_REQ(HIGH_REQ), .LOW_REQ(LOW_REQ),
    .IRQ(IRQ)
);
`default_nettype wire
